// [dv/prog_mem.sv]
/*
  program memory model facing the instruction sequencer.
  assumes one clock, and an address held steady for a whole machine cycle.
*/
`timescale 1ns/100ps
module prog_mem (
  input wire logic mclk_i,
  input wire logic [15:0] code_addr_i,
  input wire logic code_rd_i,
  output logic [7:0] code_data_o
);
  // ----------------------------------------------------------------
  // storage and access delay
  // ----------------------------------------------------------------
  logic [7:0] mem [0:2047];
  logic [15:0] prev_q = 16'hffff;
  logic [3:0] age_q = 4'h0;
  logic [7:0] last_q = 8'h5a;
  logic valid;
  // byte settles two clocks after the address, so early sampling reads junk
  assign valid = code_rd_i && (code_addr_i == prev_q) && (age_q != 4'h0);
  assign code_data_o = valid ? mem[code_addr_i[10:0]] : ~last_q;
  always_ff @(posedge mclk_i) begin
    prev_q <= code_addr_i;
    if (code_addr_i != prev_q) begin
      age_q <= 4'h0;
    end else if (age_q != 4'hf) begin
      age_q <= age_q + 4'h1;
    end
    if (valid) begin
      last_q <= mem[code_addr_i[10:0]];
    end
  end
endmodule

// [dv/tb_top.sv]
/*
  self-checking bench for the instruction sequencer: random programs with corners.
  assumes prog_mem as program memory and a reference model kept in this file.
*/
`timescale 1ns/100ps
module tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  typedef struct {
    logic [7:0] op; logic [7:0] acc; logic cy; logic ov; logic ac; logic [7:0] sp;
    int clks; int nb;
  } exp_t;
  logic mclk_i, rst_i = 1'b1, ce_i = 1'b1, code_rd, done, cy, ov, ac;
  logic [7:0] code_data, opcode, acc, sp;
  logic [15:0] code_addr;
  logic [2:0] mcycle;
  logic [1:0] phase;
  int error_cnt, n_compared, cnt, fetches, ncalls;
  bit stall_en;
  exp_t q[$];
  exp_t e;
  logic [7:0] racc, rsp;
  logic rcy, rov, rac;
  logic [15:0] pc;
  logic [7:0] ops [22] = '{8'h00, 8'h24, 8'h25, 8'h26, 8'h2f, 8'h34, 8'h35, 8'h37, 8'h38, 8'h54,
    8'h55, 8'h56, 8'h5b, 8'h52, 8'h53, 8'h82, 8'hb0, 8'hc3, 8'hd3, 8'hb3, 8'h01, 8'h11};

  insn_cycle_timing u_insn_cycle_timing (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
    .code_data_i(code_data), .code_addr_o(code_addr), .code_rd_o(code_rd),
    .insn_done_o(done), .insn_opcode_o(opcode), .acc_o(acc), .sp_o(sp),
    .carry_flag_bit_o(cy), .signed_overflow_flag_o(ov), .half_carry_flag_o(ac),
    .mcycle_o(mcycle), .phase_o(phase));
  prog_mem u_prog_mem (.mclk_i(mclk_i), .code_addr_i(code_addr), .code_rd_i(code_rd),
    .code_data_o(code_data));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // ----------------------------------------------------------------
  // reference model
  // ----------------------------------------------------------------
  task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b, input logic c);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] l;
    s = {1'b0, a} + {1'b0, b} + {8'h00, c};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c};
    l = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, c};
    return {s[8], h[4], l[7] ^ s[8], s[7:0]};
  endfunction

  // ram stays zero below 08, so register, indirect and direct operands read 00
  task automatic put(input logic [7:0] op_in, input logic [7:0] b1_in, input logic [7:0] b2);
    logic [7:0] op, b1, v;
    logic [15:0] t;
    int nb, nc;
    op = op_in;
    b1 = b1_in;
    nb = 1;
    nc = 1;
    v = 8'h00;
    if (op[3:0] == 4'h1) begin
      t = pc + 16'h0002;
      op[7:5] = t[10:8];
      b1 = t[7:0];
      nb = 2;
      nc = 3;
      if (op[4]) rsp = rsp + 8'h02;
    end else if (op inside {8'h24, 8'h34, 8'h54}) begin
      nb = 2;
      nc = 2;
      v = b1;
    end else if (op inside {8'h25, 8'h35, 8'h55, 8'h52, 8'h82, 8'hb0}) begin
      nb = 2;
      nc = 2;
    end else if (op == 8'h53) begin
      nb = 3;
      nc = 3;
    end
    if (op[3:0] >= 4'h4 && op[7:4] == 4'h2) {rcy, rac, rov, racc} = add8(racc, v, 1'b0);
    if (op[3:0] >= 4'h4 && op[7:4] == 4'h3) {rcy, rac, rov, racc} = add8(racc, v, rcy);
    if (op[3:0] >= 4'h4 && op[7:4] == 4'h5) racc = racc & v;
    if (op == 8'hc3 || op == 8'h82) rcy = 1'b0;
    if (op == 8'hd3) rcy = 1'b1;
    if (op == 8'hb3) rcy = ~rcy;
    u_prog_mem.mem[pc[10:0]] = op;
    u_prog_mem.mem[pc[10:0] + 11'h001] = b1;
    u_prog_mem.mem[pc[10:0] + 11'h002] = b2;
    pc = pc + 16'(nb);
    q.push_back('{op, racc, rcy, rov, rac, rsp, 4 * nc, nb});
  endtask

  // ----------------------------------------------------------------
  // monitor and enable stalls
  // ----------------------------------------------------------------
  always @(negedge mclk_i) begin
    if (!rst_i && ce_i) begin
      cnt++;
      if (phase == 2'h3 && code_rd === 1'b1) fetches++;
      if (done === 1'b1 && q.size() > 0) begin
        e = q.pop_front();
        cmp8("opcode", e.op, opcode);
        cmp8("acc", e.acc, acc);
        cmp8("carry", {7'h00, e.cy}, {7'h00, cy});
        cmp8("overflow", {7'h00, e.ov}, {7'h00, ov});
        cmp8("half_carry", {7'h00, e.ac}, {7'h00, ac});
        cmp8("sp", e.sp, sp);
        cmp8("clocks", 8'(e.clks), 8'(cnt));
        cmp8("fetches", 8'(e.nb), 8'(fetches));
        cmp8("mcycle", 8'h00, {5'h00, mcycle});
        cmp8("phase", 8'h00, {6'h00, phase});
        cnt = 0;
        fetches = 0;
      end
    end
    ce_i <= stall_en ? (($urandom % 4) != 0) : 1'b1;
  end

  // ----------------------------------------------------------------
  // runs
  // ----------------------------------------------------------------
  task automatic run(input bit stalls);
    logic [7:0] op;
    for (int i = 0; i < 2048; i++) u_prog_mem.mem[i] = 8'h00;
    pc = 16'h0000;
    racc = 8'h00;
    {rcy, rov, rac} = 3'h0;
    rsp = 8'h07;
    ncalls = 0;
    q.delete();
    stall_en = 1'b0;
    rst_i <= 1'b1;
    // carry out, signed overflow, half carry, ff plus 01, then every call, jump and carry form
    put(8'h24, 8'h80, 8'h00);
    put(8'h24, 8'h80, 8'h00);
    put(8'h34, 8'h0f, 8'h00);
    put(8'h24, 8'h7f, 8'h00);
    put(8'h24, 8'h70, 8'h00);
    put(8'h24, 8'h01, 8'h00);
    put(8'h11, 8'h00, 8'h00);
    put(8'h01, 8'h00, 8'h00);
    put(8'h53, 8'h03, 8'hff);
    put(8'hd3, 8'h00, 8'h00);
    put(8'hb0, 8'h90, 8'h00);
    put(8'h82, 8'h21, 8'h00);
    put(8'hb3, 8'h00, 8'h00);
    put(8'hc3, 8'h00, 8'h00);
    for (int i = 0; i < 40; i++) begin
      op = ops[$urandom % 22];
      if (op[3]) op[2:0] = 3'($urandom);
      if (op == 8'h11 && ncalls >= 6) op = 8'h00;
      if (op == 8'h11) ncalls++;
      put(op, (op inside {8'h25, 8'h35, 8'h55, 8'h52, 8'h53}) ? 8'($urandom % 8) : 8'($urandom),
        8'($urandom));
    end
    repeat (6) @(negedge mclk_i);
    cmp8("rst_acc", 8'h00, acc);
    cmp8("rst_sp", 8'h07, sp);
    cmp8("rst_flags", 8'h00, {5'h00, cy, ov, ac});
    cmp8("rst_addr", 8'h00, code_addr[15:8] | code_addr[7:0]);
    cmp8("rst_ctl", 8'h01, {6'h00, done, code_rd});
    rst_i <= 1'b0;
    cnt = 0;
    fetches = 0;
    stall_en = stalls;
    for (int n = 0; n < 8000 && q.size() > 0; n++) @(negedge mclk_i);
    if (q.size() != 0) begin
      error_cnt++;
      $display("BAD retired expected 0 seen %0d", q.size());
    end
    stall_en = 1'b0;
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(32'h90c05af4));
    @(negedge mclk_i);
    run(1'b0);
    run(1'b1);
    close_out();
  end

  initial begin
    #300000;
    error_cnt++;
    $display("BAD watchdog expected done seen hang");
    close_out();
  end
endmodule

// [verilog/decode_if.sv]
/*
  carrier between the sequencer and the opcode decoder.
  assumes the decoder is purely combinational.
*/
`timescale 1ns/100ps
interface decode_if;
  logic [7:0] opcode;
  insn_timing_pkg::op_class_t cls;
  insn_timing_pkg::src_t src;
  logic [2:0] nbytes;
  logic [2:0] ncycles;
  modport core (output opcode, input cls, input src, input nbytes, input ncycles);
  modport dec (input opcode, output cls, output src, output nbytes, output ncycles);
endinterface

// [verilog/insn_cycle_timing.sv]
/*
  instruction sequencer: 4-clock machine cycles, one code fetch per cycle except the last cycle of a call or jump,
  execution of the add, add-with-carry, and, call, jump and carry-bit rows.
  assumes program memory on mclk_i that returns the byte at code_addr_o
  by the fourth clock of a cycle in which code_rd_o is high.
*/
`timescale 1ns/100ps
module insn_cycle_timing #(
  parameter int DATA_DEPTH = 256
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [7:0] code_data_i,
  output logic [15:0] code_addr_o,
  output logic code_rd_o,
  output logic insn_done_o,
  output logic [7:0] insn_opcode_o,
  output logic [7:0] acc_o,
  output logic [7:0] sp_o,
  output logic carry_flag_bit_o,
  output logic signed_overflow_flag_o,
  output logic half_carry_flag_o,
  output logic [2:0] mcycle_o,
  output logic [1:0] phase_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  decode_if dif ();
  insn_decode u_dec (.dif(dif));

  logic [1:0] phase_q;
  logic [2:0] mc_q;
  logic [15:0] pc_q, pc_d;
  logic [7:0] op_q, b1_q, acc_q, acc_d, sp_q, sp_d;
  logic cy_q, cy_d, ov_q, ov_d, ac_q, ac_d;
  logic done_q;
  logic [7:0] done_op_q;
  logic [7:0] ram_q [DATA_DEPTH];
  logic last_phase, fetch, take, retire, jump;
  logic [7:0] opd1, src_v, wa0, wd0, wa1, wd1;
  logic we0, we1;
  logic [10:0] add_res;
  logic [15:0] jump_pc;

  function automatic logic [10:0] alu_add(input logic [7:0] a, input logic [7:0] b,
                                          input logic ci);
    logic [8:0] s;
    logic [4:0] lo;
    logic [7:0] s7;
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    s7 = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, ci};
    alu_add = {s[8], s[8] ^ s7[7], lo[4], s[7:0]};
  endfunction

  function automatic logic [7:0] bit_byte_idx(input logic [7:0] ba);
    bit_byte_idx = insn_timing_pkg::BIT_AREA_BASE + {4'h0, ba[6:3]};
  endfunction

  // special-function bits are not held here and read as zero
  function automatic logic bit_val(input logic [7:0] ba);
    logic [7:0] byte_v;
    byte_v = ram_q[bit_byte_idx(ba)];
    bit_val = (ba < insn_timing_pkg::BIT_SFR_LIMIT) & byte_v[ba[2:0]];
  endfunction

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  // the opcode is decoded from the bus while it arrives so 1-cycle forms retire on time
  assign dif.opcode = (mc_q == '0) ? code_data_i : op_q;
  assign last_phase = (phase_q == insn_timing_pkg::PHASE_LAST);
  assign fetch = (mc_q < dif.nbytes);
  assign take = ce_i & last_phase & fetch;
  assign retire = ce_i & last_phase & (mc_q == dif.ncycles - insn_timing_pkg::CNT_1);
  assign jump = (dif.cls == insn_timing_pkg::C_ACALL) || (dif.cls == insn_timing_pkg::C_AJMP);
  assign opd1 = (mc_q == insn_timing_pkg::CNT_1) ? code_data_i : b1_q;
  assign jump_pc = {pc_q[15:11], op_q[7:5], b1_q};

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      phase_q <= insn_timing_pkg::PHASE_FIRST;
    end else if (ce_i) begin
      phase_q <= phase_q + 2'h1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mc_q <= '0;
    end else if (ce_i && last_phase) begin
      mc_q <= retire ? '0 : mc_q + insn_timing_pkg::CNT_1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      op_q <= '0;
      b1_q <= '0;
    end else if (take) begin
      if (mc_q == '0) begin
        op_q <= code_data_i;
      end else if (mc_q == insn_timing_pkg::CNT_1) begin
        b1_q <= code_data_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // execution
  // ----------------------------------------------------------------
  always_comb begin
    unique case (dif.src)
      insn_timing_pkg::SRC_REG: src_v = ram_q[{5'h00, dif.opcode[2:0]}];
      insn_timing_pkg::SRC_IND: src_v = ram_q[ram_q[{7'h00, dif.opcode[0]}]];
      insn_timing_pkg::SRC_DIR: src_v = ram_q[opd1];
      insn_timing_pkg::SRC_IMM: src_v = opd1;
    endcase
  end

  assign add_res = alu_add(acc_q, src_v, (dif.cls == insn_timing_pkg::C_ADDC) & cy_q);

  always_comb begin
    acc_d = acc_q;
    cy_d = cy_q;
    ov_d = ov_q;
    ac_d = ac_q;
    sp_d = sp_q;
    pc_d = take ? pc_q + insn_timing_pkg::PC_STEP : pc_q;
    we0 = 1'b0;
    wa0 = opd1;
    wd0 = acc_q;
    we1 = 1'b0;
    wa1 = sp_q + insn_timing_pkg::SP_STEP + insn_timing_pkg::SP_STEP;
    wd1 = pc_q[15:8];
    if (retire) begin
      unique case (dif.cls)
        insn_timing_pkg::C_NOP: acc_d = acc_q;
        insn_timing_pkg::C_ADD, insn_timing_pkg::C_ADDC: begin
          acc_d = add_res[7:0];
          cy_d = add_res[10];
          ov_d = add_res[9];
          ac_d = add_res[8];
        end
        insn_timing_pkg::C_ANL_A: acc_d = acc_q & src_v;
        insn_timing_pkg::C_ANL_DIR_A: begin
          we0 = 1'b1;
          wd0 = ram_q[opd1] & acc_q;
        end
        insn_timing_pkg::C_ANL_DIR_IMM: begin
          we0 = 1'b1;
          wa0 = b1_q;
          wd0 = ram_q[b1_q] & code_data_i;
        end
        insn_timing_pkg::C_ANL_C_BIT: cy_d = cy_q & bit_val(opd1);
        insn_timing_pkg::C_ANL_C_NBIT: cy_d = cy_q & ~bit_val(opd1);
        insn_timing_pkg::C_CLR_C: cy_d = 1'b0;
        insn_timing_pkg::C_SETB_C: cy_d = 1'b1;
        insn_timing_pkg::C_CPL_C: cy_d = ~cy_q;
        insn_timing_pkg::C_ACALL: begin
          // return address pushed low byte first, as the standard set does
          we0 = 1'b1;
          wa0 = sp_q + insn_timing_pkg::SP_STEP;
          wd0 = pc_q[7:0];
          we1 = 1'b1;
          sp_d = wa1;
          pc_d = jump_pc;
        end
        insn_timing_pkg::C_AJMP: pc_d = jump_pc;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pc_q <= insn_timing_pkg::PC_RESET;
      acc_q <= '0;
      sp_q <= insn_timing_pkg::SP_RESET;
      cy_q <= 1'b0;
      ov_q <= 1'b0;
      ac_q <= 1'b0;
    end else if (ce_i) begin
      pc_q <= pc_d;
      acc_q <= acc_d;
      sp_q <= sp_d;
      cy_q <= cy_d;
      ov_q <= ov_d;
      ac_q <= ac_d;
    end
  end

  // reset of the whole data store costs area; traded for deterministic simulation
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DATA_DEPTH; i++) begin
        ram_q[i] <= '0;
      end
    end else if (ce_i) begin
      if (we0) begin
        ram_q[wa0] <= wd0;
      end
      if (we1) begin
        ram_q[wa1] <= wd1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
      done_op_q <= '0;
    end else if (ce_i) begin
      done_q <= retire;
      if (retire) begin
        done_op_q <= dif.opcode;
      end
    end
  end

  assign code_addr_o = pc_q;
  assign code_rd_o = fetch;
  assign insn_done_o = done_q;
  assign insn_opcode_o = done_op_q;
  assign acc_o = acc_q;
  assign sp_o = sp_q;
  assign carry_flag_bit_o = cy_q;
  assign signed_overflow_flag_o = ov_q;
  assign half_carry_flag_o = ac_q;
  assign mcycle_o = mc_q;
  assign phase_o = phase_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [4:0] clk_cnt_q;
  logic [2:0] fetch_cnt_q;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      clk_cnt_q <= '0;
      fetch_cnt_q <= '0;
    end else if (ce_i) begin
      clk_cnt_q <= retire ? '0 : clk_cnt_q + 5'h01;
      fetch_cnt_q <= retire ? '0 : fetch_cnt_q + {2'h0, take};
    end
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  chk_phase_wrap: assert property (ce_i && last_phase |=> phase_q == insn_timing_pkg::PHASE_FIRST)
    else $error("machine cycle did not wrap after four clocks");
  chk_insn_clocks: assert property (retire |->
      clk_cnt_q == 5'(5'(dif.ncycles) * 5'(insn_timing_pkg::PHASES) - 1))
    else $error("instruction length is not its cycle count times four");
  chk_fetch_steady: assert property (ce_i && !last_phase |=> $stable(code_rd_o) &&
      $stable(code_addr_o))
    else $error("fetch request moved inside a machine cycle");
  chk_byte_count: assert property (retire && !jump |-> dif.ncycles == dif.nbytes &&
      fetch_cnt_q + {2'h0, take} == dif.nbytes)
    else $error("cycle count differs from fetched byte count");
  chk_jump_extra: assert property (retire && jump |-> !code_rd_o &&
      dif.ncycles == dif.nbytes + insn_timing_pkg::JUMP_EXTRA ##1 pc_q == $past(jump_pc))
    else $error("jump missed its address cycle or target");
  chk_add_flags: assert property (retire && dif.cls == insn_timing_pkg::C_ADD &&
      dif.src == insn_timing_pkg::SRC_IMM && acc_q == 8'hff && opd1 == 8'h01 |=>
      acc_o == 8'h00 && carry_flag_bit_o && half_carry_flag_o && !signed_overflow_flag_o)
    else $error("add flags wrong for ff plus 01");
  chk_carry_force: assert property (retire && dif.cls == insn_timing_pkg::C_CLR_C |=>
      !carry_flag_bit_o && $stable(signed_overflow_flag_o) && $stable(half_carry_flag_o))
    else $error("clear carry misbehaved");
  chk_setb_carry: assert property (retire && dif.cls == insn_timing_pkg::C_SETB_C |=>
      carry_flag_bit_o)
    else $error("set carry did not set");
  chk_one_cycle: assert property (retire && dif.opcode[3] &&
      (dif.cls == insn_timing_pkg::C_ADD || dif.cls == insn_timing_pkg::C_ANL_A) |->
      clk_cnt_q == 5'(insn_timing_pkg::CLKS_1MC - 1))
    else $error("register form not one machine cycle");
  chk_two_cycle: assert property (retire &&
      (dif.opcode == insn_timing_pkg::OP_ANL_C_BIT || dif.opcode == insn_timing_pkg::OP_ANL_DIR_A)
      |-> clk_cnt_q == 5'(insn_timing_pkg::CLKS_2MC - 1))
    else $error("two-cycle form has wrong length");
  chk_three_cycle: assert property (retire &&
      (jump || dif.cls == insn_timing_pkg::C_ANL_DIR_IMM) |->
      clk_cnt_q == 5'(insn_timing_pkg::CLKS_3MC - 1))
    else $error("three-cycle form has wrong length");
  chk_reg_decode: assert property (retire && dif.opcode[3] &&
      dif.opcode[7:4] == insn_timing_pkg::HI_ADDC |->
      dif.cls == insn_timing_pkg::C_ADDC && dif.src == insn_timing_pkg::SRC_REG)
    else $error("register form decoded wrongly");
  chk_abs_decode: assert property (mc_q != '0 && op_q[3:0] == insn_timing_pkg::LO_ABS |->
      dif.cls == (op_q[4] ? insn_timing_pkg::C_ACALL : insn_timing_pkg::C_AJMP))
    else $error("absolute call or jump decoded wrongly");
  chk_call_push: assert property (retire && dif.cls == insn_timing_pkg::C_ACALL |=>
      sp_o == $past(sp_o) + 8'h02)
    else $error("call did not push two bytes");

  cov_call: cover property (retire && dif.cls == insn_timing_pkg::C_ACALL);
  cov_anl_imm: cover property (retire && dif.cls == insn_timing_pkg::C_ANL_DIR_IMM);
  cov_add_carry: cover property (retire && dif.cls == insn_timing_pkg::C_ADD && add_res[10]);
  cov_stall: cover property (!ce_i && mc_q != '0);

endmodule

// [verilog/insn_decode.sv]
/*
  opcode decoder: class, operand source, byte count and machine cycle count.
  assumes the opcode on the interface is stable while its answer is used.
*/
`timescale 1ns/100ps
module insn_decode (
  decode_if.dec dif
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [7:0] op;
  logic alu_row;

  assign op = dif.opcode;
  assign alu_row = (op[7:4] == insn_timing_pkg::HI_ADD) ||
                   (op[7:4] == insn_timing_pkg::HI_ADDC) ||
                   (op[7:4] == insn_timing_pkg::HI_ANL);

  always_comb begin
    // unlisted opcodes run as one-byte no-ops
    dif.cls = insn_timing_pkg::C_NOP;
    dif.src = insn_timing_pkg::SRC_REG;
    dif.nbytes = insn_timing_pkg::CNT_1;
    dif.ncycles = insn_timing_pkg::CNT_1;
    if (op[3:0] == insn_timing_pkg::LO_ABS) begin
      dif.cls = op[4] ? insn_timing_pkg::C_ACALL : insn_timing_pkg::C_AJMP;
      dif.nbytes = insn_timing_pkg::CNT_2;
      dif.ncycles = insn_timing_pkg::CNT_2 + insn_timing_pkg::JUMP_EXTRA;
    end else if (alu_row && (op[3] || op[3:2] == insn_timing_pkg::LO_MEM_FORM)) begin
      if (op[7:4] == insn_timing_pkg::HI_ADD) begin
        dif.cls = insn_timing_pkg::C_ADD;
      end else if (op[7:4] == insn_timing_pkg::HI_ADDC) begin
        dif.cls = insn_timing_pkg::C_ADDC;
      end else begin
        dif.cls = insn_timing_pkg::C_ANL_A;
      end
      if (op[3]) begin
        dif.src = insn_timing_pkg::SRC_REG;
      end else if (op[1]) begin
        dif.src = insn_timing_pkg::SRC_IND;
      end else if (op[0]) begin
        dif.src = insn_timing_pkg::SRC_DIR;
      end else begin
        dif.src = insn_timing_pkg::SRC_IMM;
      end
      dif.nbytes = (op[3] || op[1]) ? insn_timing_pkg::CNT_1 : insn_timing_pkg::CNT_2;
      dif.ncycles = dif.nbytes;
    end else begin
      unique case (op)
        insn_timing_pkg::OP_ANL_DIR_A: begin
          dif.cls = insn_timing_pkg::C_ANL_DIR_A;
          dif.nbytes = insn_timing_pkg::CNT_2;
          dif.ncycles = insn_timing_pkg::CNT_2;
        end
        insn_timing_pkg::OP_ANL_DIR_IMM: begin
          dif.cls = insn_timing_pkg::C_ANL_DIR_IMM;
          dif.nbytes = insn_timing_pkg::CNT_3;
          dif.ncycles = insn_timing_pkg::CNT_3;
        end
        insn_timing_pkg::OP_ANL_C_BIT: begin
          dif.cls = insn_timing_pkg::C_ANL_C_BIT;
          dif.nbytes = insn_timing_pkg::CNT_2;
          dif.ncycles = insn_timing_pkg::CNT_2;
        end
        insn_timing_pkg::OP_ANL_C_NBIT: begin
          dif.cls = insn_timing_pkg::C_ANL_C_NBIT;
          dif.nbytes = insn_timing_pkg::CNT_2;
          dif.ncycles = insn_timing_pkg::CNT_2;
        end
        insn_timing_pkg::OP_CLR_C: dif.cls = insn_timing_pkg::C_CLR_C;
        insn_timing_pkg::OP_SETB_C: dif.cls = insn_timing_pkg::C_SETB_C;
        insn_timing_pkg::OP_CPL_C: dif.cls = insn_timing_pkg::C_CPL_C;
        default: dif.cls = insn_timing_pkg::C_NOP;
      endcase
    end
  end

endmodule

// [verilog/insn_timing_pkg.sv]
/*
  constants and types for the instruction cycle timing core.
  assumes a single clock domain; opcodes follow the standard 8-bit accumulator set.
*/
package insn_timing_pkg;

  // ----------------------------------------------------------------
  // machine cycle
  // ----------------------------------------------------------------
  localparam int PHASES = 4;
  localparam logic [1:0] PHASE_FIRST = 2'h0;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam int CLKS_1MC = 1 * PHASES;
  localparam int CLKS_2MC = 2 * PHASES;
  localparam int CLKS_3MC = 3 * PHASES;

  // ----------------------------------------------------------------
  // counts and resets
  // ----------------------------------------------------------------
  localparam logic [2:0] CNT_1 = 3'h1;
  localparam logic [2:0] CNT_2 = 3'h2;
  localparam logic [2:0] CNT_3 = 3'h3;
  localparam logic [2:0] JUMP_EXTRA = 3'h1;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] SP_STEP = 8'h01;
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;
  localparam logic [7:0] BIT_SFR_LIMIT = 8'h80;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [3:0] HI_ADD = 4'h2;
  localparam logic [3:0] HI_ADDC = 4'h3;
  localparam logic [3:0] HI_ANL = 4'h5;
  localparam logic [3:0] LO_ABS = 4'h1;
  localparam logic [1:0] LO_MEM_FORM = 2'h1;
  localparam logic [7:0] OP_ANL_DIR_A = 8'h52;
  localparam logic [7:0] OP_ANL_DIR_IMM = 8'h53;
  localparam logic [7:0] OP_ANL_C_BIT = 8'h82;
  localparam logic [7:0] OP_ANL_C_NBIT = 8'hb0;
  localparam logic [7:0] OP_CPL_C = 8'hb3;
  localparam logic [7:0] OP_CLR_C = 8'hc3;
  localparam logic [7:0] OP_SETB_C = 8'hd3;

  typedef enum logic [3:0] {
    C_NOP, C_ADD, C_ADDC, C_ANL_A, C_ANL_DIR_A, C_ANL_DIR_IMM, C_ANL_C_BIT,
    C_ANL_C_NBIT, C_CLR_C, C_SETB_C, C_CPL_C, C_ACALL, C_AJMP
  } op_class_t;

  typedef enum logic [1:0] {SRC_REG, SRC_IND, SRC_DIR, SRC_IMM} src_t;

endpackage
